// File: logic/event_trace_pkg.sv
// constants and types for the hardware event trace control bank
// assumes a plain register port on one 25 MHz clock with asynchronous active-high reset
package event_trace_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register byte addresses, one aligned word each
  localparam logic [3:0] MAIN_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] EXT_MUX_ADDR = 4'h4;
  localparam logic [3:0] MASTER_NUMBER_ADDR = 4'h8;
  localparam logic [3:0] FEATURES_ADDR = 4'hC;
  // main control field positions
  localparam int GLOBAL_EN_BIT = 0;
  localparam int LOCAL_EN_BIT = 0;
  localparam int ZERO_SUPPRESS_BIT = 1;
  localparam int LOSS_DETECT_BIT = 2;
  localparam logic LOCAL_EN_RESET = 1'h0;
  localparam logic ZERO_SUPPRESS_RESET = 1'h0;
  localparam logic LOSS_DETECT_RESET = 1'h0;
  // feature register field positions
  localparam int WIDTH_CODE_LSB = 28;
  localparam int COMP_CODE_LSB = 4;
  localparam int MASTER_WR_BIT = 3;
  localparam int LOSS_SUPPORT_BIT = 2;
  localparam logic [1:0] COMP_PROGRAMMABLE = 2'h3;
  // master number
  localparam int MASTER_W = 16;
  localparam logic [15:0] MASTER_RESET_DEFAULT = 16'h0000;
  localparam logic [31:0] MUX_RESET = 32'h00000000;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage : event_trace_pkg

// File: logic/reg_port_if.sv
// register write carrier between top and the source select holder
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface reg_port_if;
  logic writeHit;
  logic [31:0] writeData;
  logic [31:0] fieldValue;
  modport master (output writeHit, output writeData, input fieldValue);
  modport slave (input writeHit, input writeData, output fieldValue);
endinterface : reg_port_if
`default_nettype wire

// File: logic/source_select_reg.sv
// width-masked source select holder for the external mux
// assumes the write hit is already address decoded
`timescale 1ns/1ns
`default_nettype none
module source_select_reg
#(
  parameter logic [2:0] WIDTH_CODE = 3'h3
)
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset
  reg_port_if.slave port // write in, value out
);
  localparam logic [31:0] FIELD_MASK =
    (WIDTH_CODE == 3'h1) ? 32'h00000003 :
    (WIDTH_CODE == 3'h2) ? 32'h0000000F :
    (WIDTH_CODE == 3'h3) ? 32'h000000FF :
    (WIDTH_CODE == 3'h4) ? 32'h0000FFFF :
    (WIDTH_CODE == 3'h5) ? 32'hFFFFFFFF : 32'h00000000;
  logic [31:0] value;
  if (WIDTH_CODE > 3'h5)
  begin : reservedCode
    $error("source select width code reserved");
  end

  ////////////////////////////////////////////////////////////////
  // masked storage, absent code keeps zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      value <= event_trace_pkg::MUX_RESET;
    else if (port.writeHit)
      value <= port.writeData & FIELD_MASK;
  end
  assign port.fieldValue = value;

  mux_width_a: assert property (@(posedge clk_sys) disable iff (rst) (value & ~FIELD_MASK) == 32'h0)
    else $error("source select holds bits above its width");
  mux_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    port.writeHit |=> value == ($past(port.writeData) & FIELD_MASK))
    else $error("source select write lost");
endmodule : source_select_reg
`default_nettype wire

// File: logic/hw_event_trace_control.sv
// hardware event trace control bank: main control, source select, master number, features
// assumes a plain register port, read data one cycle after the read strobe
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module hw_event_trace_control
#(
  parameter logic [2:0] WIDTH_CODE = 3'h3, // source select width code
  parameter logic [1:0] COMP_CODE = 2'h3, // compression support code
  parameter logic MASTER_WRITABLE = 1'b1, // master number writable
  parameter logic LOSS_SUPPORT = 1'b1, // loss detection implemented
  parameter logic [15:0] MASTER_RESET = event_trace_pkg::MASTER_RESET_DEFAULT // arbitrary build value
)
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic [3:0] addr, // byte address
  input wire logic [31:0] wrData, // write data
  input wire logic wrStrobe, // write strobe
  input wire logic rdStrobe, // read strobe
  output logic [31:0] rdData, // read data, cycle after strobe
  input wire logic global_trace_enable, // trace unit enable
  input wire logic eventLost, // event could not be traced
  output logic traceActive, // event tracing allowed
  output logic zero_suppress_enable, // suppression in effect
  output logic lossIndicate, // lost information pulse
  output logic [31:0] source_select_value, // to outside mux
  output logic [15:0] masterNumber // master identity
);
  if (WIDTH_CODE > 3'h5)
  begin : reservedWidth
    $error("width code reserved");
  end
  // master port is fixed at 16 bits, so the package width must agree
  if (event_trace_pkg::MASTER_W != 16)
  begin : masterWidth
    $error("master number width must be 16");
  end

  ////////////////////////////////////////////////////////////////
  // decode
  wire hitMain = addr == event_trace_pkg::MAIN_CONTROL_ADDR;
  wire hitMux = addr == event_trace_pkg::EXT_MUX_ADDR;
  wire hitMaster = addr == event_trace_pkg::MASTER_NUMBER_ADDR;
  wire hitFeat = addr == event_trace_pkg::FEATURES_ADDR;
  wire lossImpl = LOSS_SUPPORT;
  wire compImpl = COMP_CODE == event_trace_pkg::COMP_PROGRAMMABLE;
  // register present only for nonzero code
  wire muxImpl = WIDTH_CODE != 3'h0;
  wire masterWr = wrStrobe && hitMaster && MASTER_WRITABLE;
  // read hits, used by the readback checks below
  wire rdMain = rdStrobe && hitMain;
  wire rdMux = rdStrobe && hitMux;
  wire rdMaster = rdStrobe && hitMaster;
  wire rdFeat = rdStrobe && hitFeat;
  wire rdOther = rdStrobe && !(hitMain || hitMux || hitMaster || hitFeat);

  logic localEn;
  logic zeroSuppress;
  logic lossDetect;
  logic [31:0] next_rdData;

  ////////////////////////////////////////////////////////////////
  // main control bits
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      localEn <= event_trace_pkg::LOCAL_EN_RESET;
      zeroSuppress <= event_trace_pkg::ZERO_SUPPRESS_RESET;
      lossDetect <= event_trace_pkg::LOSS_DETECT_RESET;
    end
    else if (wrStrobe && hitMain)
    begin
      localEn <= wrData[event_trace_pkg::LOCAL_EN_BIT];
      zeroSuppress <= wrData[event_trace_pkg::ZERO_SUPPRESS_BIT] & compImpl;
      lossDetect <= wrData[event_trace_pkg::LOSS_DETECT_BIT] & lossImpl;
    end
  end

  ////////////////////////////////////////////////////////////////
  // master number, reset value fixed at build
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      masterNumber <= MASTER_RESET;
    else if (masterWr)
      masterNumber <= wrData[event_trace_pkg::MASTER_W-1:0];
  end

  ////////////////////////////////////////////////////////////////
  // source select holder drives outside mux
  reg_port_if muxPort();
  assign muxPort.writeHit = wrStrobe && hitMux && muxImpl;
  assign muxPort.writeData = wrData;
  source_select_reg #(.WIDTH_CODE(WIDTH_CODE)) selectReg
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .port(muxPort)
  );
  assign source_select_value = muxPort.fieldValue;

  ////////////////////////////////////////////////////////////////
  // both enables needed
  assign traceActive = localEn && global_trace_enable;
  // compression always on for code 2 while tracing is active
  assign zero_suppress_enable = traceActive && (zeroSuppress || COMP_CODE == 2'h2);
  // loss flagged only while tracing with detection on
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      lossIndicate <= 1'b0;
    else
      lossIndicate <= eventLost && lossDetect && traceActive;
  end

  ////////////////////////////////////////////////////////////////
  // main control word, absent and reserved bits left zero
  logic [31:0] mainRead;
  always_comb
  begin
    mainRead = event_trace_pkg::READ_ZERO;
    mainRead[event_trace_pkg::LOCAL_EN_BIT] = localEn;
    mainRead[event_trace_pkg::ZERO_SUPPRESS_BIT] = zeroSuppress;
    mainRead[event_trace_pkg::LOSS_DETECT_BIT] = lossDetect;
  end
  // feature word is fixed at build, so software can size the other registers before touching them
  logic [31:0] featRead;
  always_comb
  begin
    featRead = event_trace_pkg::READ_ZERO;
    featRead[event_trace_pkg::WIDTH_CODE_LSB +: 3] = WIDTH_CODE;
    featRead[event_trace_pkg::COMP_CODE_LSB +: 2] = COMP_CODE;
    featRead[event_trace_pkg::MASTER_WR_BIT] = MASTER_WRITABLE;
    featRead[event_trace_pkg::LOSS_SUPPORT_BIT] = LOSS_SUPPORT;
  end
  // read mux, unmapped reads zero
  always_comb
  begin
    next_rdData = event_trace_pkg::READ_ZERO;
    if (hitMain)
      next_rdData = mainRead;
    else if (hitMux)
      next_rdData = source_select_value;
    else if (hitMaster)
      next_rdData = {16'h0, masterNumber};
    else if (hitFeat)
      next_rdData = featRead;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdData <= event_trace_pkg::READ_ZERO;
    else if (rdStrobe)
      rdData <= next_rdData;
    else
      rdData <= event_trace_pkg::READ_ZERO;
  end

  ////////////////////////////////////////////////////////////////
  // enable gating
  trace_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrStrobe && hitMain && !wrData[event_trace_pkg::LOCAL_EN_BIT]) |=> !traceActive)
    else $error("tracing stays on after local enable cleared");
  loss_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    (eventLost && lossDetect && traceActive) |=> lossIndicate)
    else $error("lost event not flagged");
  silent_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    !lossDetect |=> !lossIndicate)
    else $error("loss flagged with detection off");
  master_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !MASTER_WRITABLE |=> $stable(masterNumber))
    else $error("read-only master number changed");
  loss_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrStrobe && hitMain && lossImpl) |=> lossDetect == $past(wrData[event_trace_pkg::LOSS_DETECT_BIT]))
    else $error("loss detect write lost");
  comp_absent_a: assert property (@(posedge clk_sys) disable iff (rst)
    !compImpl |-> !zeroSuppress)
    else $error("suppression set while absent");
  master_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rdStrobe && hitMaster && !masterWr) |=> rdData == {16'h0, masterNumber})
    else $error("master readback wrong");
  local_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrStrobe && hitMain) |=> localEn == $past(wrData[event_trace_pkg::LOCAL_EN_BIT]))
    else $error("local enable write lost");

  ////////////////////////////////////////////////////////////////
  // reset values seen at the first edge after release
  // enable resets off
  enable_reset_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> localEn == event_trace_pkg::LOCAL_EN_RESET)
    else $error("local enable not cleared by reset");
  select_reset_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> source_select_value == event_trace_pkg::MUX_RESET)
    else $error("source select not cleared by reset");
  master_reset_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> masterNumber == MASTER_RESET)
    else $error("master number not at build value after reset");

  ////////////////////////////////////////////////////////////////
  // control bits change only on a main control write
  // suppression write lands
  suppress_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrStrobe && hitMain && compImpl) |=> zeroSuppress == $past(wrData[event_trace_pkg::ZERO_SUPPRESS_BIT]))
    else $error("suppression write lost");
  enable_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(wrStrobe && hitMain) |=> $stable(localEn))
    else $error("local enable changed without a write");
  suppress_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(wrStrobe && hitMain) |=> $stable(zeroSuppress))
    else $error("suppression bit changed without a write");
  loss_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(wrStrobe && hitMain) |=> $stable(lossDetect))
    else $error("loss detect bit changed without a write");
  loss_absent_a: assert property (@(posedge clk_sys) disable iff (rst)
    !lossImpl |-> !lossDetect)
    else $error("loss detect set while absent");
  suppress_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!compImpl && COMP_CODE != 2'h2) |-> !zero_suppress_enable)
    else $error("suppression in effect while not supported");

  ////////////////////////////////////////////////////////////////
  // a loss pulse needs a cause one cycle earlier
  // pulse needs cause
  loss_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    lossIndicate |-> $past(eventLost && lossDetect && traceActive))
    else $error("loss flagged without a lost event");
  loss_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !traceActive |=> !lossIndicate)
    else $error("loss flagged while tracing is off");

  ////////////////////////////////////////////////////////////////
  // master number and source select storage
  // write lands when writable
  master_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    masterWr |=> masterNumber == $past(wrData[event_trace_pkg::MASTER_W-1:0]))
    else $error("master number write lost");
  master_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    !masterWr |=> $stable(masterNumber))
    else $error("master number changed without a write");
  select_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(wrStrobe && hitMux) |=> $stable(source_select_value))
    else $error("source select changed without a write");
  select_absent_a: assert property (@(posedge clk_sys) disable iff (rst)
    !muxImpl |-> source_select_value == event_trace_pkg::MUX_RESET)
    else $error("absent source select not zero");

  ////////////////////////////////////////////////////////////////
  // readback in the cycle after the read strobe
  // main readback, loss detect bit only
  main_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdMain |=> rdData[event_trace_pkg::LOSS_DETECT_BIT] == lossDetect)
    else $error("main control readback wrong");
  mux_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdMux |=> rdData == source_select_value)
    else $error("source select readback wrong");
  mux_absent_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rdMux && !muxImpl) |=> rdData == event_trace_pkg::READ_ZERO)
    else $error("absent source select reads nonzero");
  master_upper_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdMaster |=> rdData[31:16] == 16'h0000)
    else $error("master reserved bits read nonzero");
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdOther |=> rdData == event_trace_pkg::READ_ZERO)
    else $error("unmapped address reads nonzero");
  feature_width_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdFeat |=> rdData[event_trace_pkg::WIDTH_CODE_LSB +: 3] == WIDTH_CODE)
    else $error("width code readback wrong");
  feature_master_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdFeat |=> rdData[event_trace_pkg::MASTER_WR_BIT] == MASTER_WRITABLE)
    else $error("writable flag readback wrong");
  feature_comp_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdFeat |=> rdData[event_trace_pkg::COMP_CODE_LSB +: 2] == COMP_CODE)
    else $error("compression code readback wrong");
  feature_loss_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdFeat |=> rdData[event_trace_pkg::LOSS_SUPPORT_BIT] == LOSS_SUPPORT)
    else $error("loss support flag readback wrong");
endmodule : hw_event_trace_control
`default_nettype wire

// File: testbench/hw_event_trace_control_tb_top.sv
// self-checking bench for the hardware event trace control bank
// assumes a full build and a lean build that share one register port
`timescale 1ns/1ns
`default_nettype none
module hw_event_trace_control_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wrData = 32'h00000000;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic global_trace_enable = 1'b0;
  logic eventLost = 1'b0;
  logic [31:0] rdData, rdDataLean, source_select_value, selectLean;
  logic traceActive, zero_suppress_enable, lossIndicate, lossLean, suppressLean, activeLean;
  logic [15:0] masterNumber, masterLean;
  int error_cnt = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  always
  begin
    #20 clk_sys = ~clk_sys;
  end
  // full build: 8-bit select, programmable suppression, writable master
  hw_event_trace_control dut
  (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .global_trace_enable(global_trace_enable), .eventLost(eventLost),
    .traceActive(traceActive), .zero_suppress_enable(zero_suppress_enable), .lossIndicate(lossIndicate),
    .source_select_value(source_select_value), .masterNumber(masterNumber)
  );
  // lean build: no mux register, no suppression bit, read-only master, no loss detection
  hw_event_trace_control #(.WIDTH_CODE(3'h0), .COMP_CODE(2'h1), .MASTER_WRITABLE(1'b0),
    .LOSS_SUPPORT(1'b0), .MASTER_RESET(16'h1234)) dutLean
  (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdDataLean), .global_trace_enable(global_trace_enable), .eventLost(eventLost),
    .traceActive(activeLean), .zero_suppress_enable(suppressLean), .lossIndicate(lossLean),
    .source_select_value(selectLean), .masterNumber(masterLean)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
  endtask : wr
  // read data stands one cycle only, so the following cycle must show zero
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] eLean);
    @(posedge clk_sys);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk_sys);
    rdStrobe <= 1'b0;
    @(negedge clk_sys);
    check(rdData, e);
    check(rdDataLean, eLean);
    @(negedge clk_sys);
    check(rdData, 32'h00000000);
  endtask : rd
  // one lost event; the lean build never flags
  task automatic lose(input logic e);
    @(posedge clk_sys);
    eventLost <= 1'b1;
    @(posedge clk_sys);
    eventLost <= 1'b0;
    @(negedge clk_sys);
    check({31'h0, lossIndicate}, {31'h0, e});
    check({31'h0, lossLean}, 32'h00000000);
    @(negedge clk_sys);
    check({31'h0, lossIndicate}, 32'h00000000);
  endtask : lose
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, so a stuck run still reports
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 32'h00000000, 32'h00000000);
    rd(4'h4, 32'h00000000, 32'h00000000);
    rd(4'h8, 32'h00000000, 32'h00001234);
    rd(4'hC, 32'h3000003C, 32'h00000010);
    check(source_select_value, 32'h00000000);
    // all ones: only implemented control bits stick
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0, 32'h00000007, 32'h00000001);
    check({30'h0, traceActive, activeLean}, 32'h00000000);
    @(posedge clk_sys);
    global_trace_enable <= 1'b1;
    @(negedge clk_sys);
    check({28'h0, traceActive, zero_suppress_enable, suppressLean, activeLean}, 32'h0000000D);
    lose(1'b1);
    wr(4'h0, 32'h00000003);
    lose(1'b0);
    wr(4'h0, 32'h00000006);
    @(negedge clk_sys);
    check({30'h0, traceActive, zero_suppress_enable}, 32'h00000000);
    lose(1'b0);
    // select field masked to its width; lean build has no register
    wr(4'h4, 32'hFFFFFFFF);
    rd(4'h4, 32'h000000FF, 32'h00000000);
    wr(4'h4, 32'hA5A5A5A5);
    rd(4'h4, 32'h000000A5, 32'h00000000);
    check(source_select_value, 32'h000000A5);
    check(selectLean, 32'h00000000);
    // master number writable only in the full build
    wr(4'h8, 32'hDEADBEEF);
    rd(4'h8, 32'h0000BEEF, 32'h00001234);
    check({16'h0, masterNumber}, 32'h0000BEEF);
    check({16'h0, masterLean}, 32'h00001234);
    // feature word ignores writes, unmapped reads zero
    wr(4'hC, 32'h00000000);
    rd(4'hC, 32'h3000003C, 32'h00000010);
    rd(4'h2, 32'h00000000, 32'h00000000);
    // second reset in mid-run
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 32'h00000000, 32'h00000000);
    rd(4'h4, 32'h00000000, 32'h00000000);
    rd(4'h8, 32'h00000000, 32'h00001234);
    wrap_up();
  end
endmodule : hw_event_trace_control_tb_top
`default_nettype wire
